// [tap_act_chk.sv]
// Checker for the tap and activity register bank.
// Assumes the single clock hclk and the async active-low hresetn.
`timescale 1ns/1ps
module tap_act_chk (
  input wire logic                  hclk,
  input wire logic                  hresetn,
  input wire logic                  hsel,
  input wire logic                  hwrite,
  input wire logic                  hready,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic                  tap_event,
  input wire logic                  odr_tick,
  input wire logic                  tap_irq,
  input wire tap_act_pkg::tap_cfg_t cfg,
  input wire logic [15:0]           activity_threshold_mg,
  input wire logic [11:0]           activity_duration_ticks
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       src_rd;
  logic [7:0] step;
  assign src_rd = hsel && hready && htrans == tap_act_pkg::htrans_nonseq && !hwrite &&
                  haddr[9:2] == tap_act_pkg::idx_tap_src;
  assign step = cfg.fs == 2'h0 ? tap_act_pkg::step_2g :
                cfg.fs == 2'h1 ? tap_act_pkg::step_4g :
                cfg.fs == 2'h2 ? tap_act_pkg::step_8g : tap_act_pkg::step_16g;
  sequence s_evt0; tap_event && !cfg.latch && cfg.latency == 8'h00 ##1 !tap_event; endsequence
  sequence s_pulse; tap_irq ##1 !tap_irq; endsequence
  // Outputs derived from cfg may lag it by a cycle, so only settled cfg is judged
  sequence s_calm; $past(hresetn) && $stable(cfg); endsequence
  property p_pulse0; s_evt0 |-> s_pulse; endproperty
  property p_set; tap_event |=> tap_irq; endproperty
  property p_clr; src_rd && cfg.latch && !tap_event |=> !tap_irq; endproperty
  property p_hold; cfg.latch && tap_irq && !src_rd |=> tap_irq; endproperty
  property p_six; s_calm |-> !cfg.low_power |-> cfg.activity_threshold == 7'h00 && activity_threshold_mg == 16'h0000; endproperty
  property p_mg; s_calm |-> activity_threshold_mg == 16'(cfg.activity_threshold) * 16'(step); endproperty
  property p_dur; s_calm |-> activity_duration_ticks == 12'(cfg.activity_duration) * 12'h008 + 12'h001; endproperty
  // A nonzero latency never lets an unlatched pulse end on the cycle it starts
  property p_keep; $rose(tap_irq) && !cfg.latch && cfg.latency != 8'h00 |=> tap_irq; endproperty
  property p_rdy; $past(hresetn) |-> hreadyout && !hresp; endproperty
  a_pulse0: assert property (p_pulse0) else $error("zero latency pulse wrong");
  a_set: assert property (p_set) else $error("tap event not raised");
  a_clr: assert property (p_clr) else $error("latched irq not cleared");
  a_hold: assert property (p_hold) else $error("latched irq dropped");
  a_six: assert property (p_six) else $error("threshold outside low power");
  a_mg: assert property (p_mg) else $error("threshold scaling wrong");
  a_dur: assert property (p_dur) else $error("duration ticks wrong");
  a_keep: assert property (p_keep) else $error("unlatched irq ended early");
  a_rdy: assert property (p_rdy) else $error("bus answer wrong");
endmodule // tap_act_chk
bind tap_act_regs tap_act_chk u_chk (.hclk, .hresetn, .hsel, .hwrite, .hready, .haddr, .htrans,
  .hreadyout, .hresp, .tap_event, .odr_tick, .tap_irq, .cfg, .activity_threshold_mg, .activity_duration_ticks);

// [tap_act_pkg.sv]
// Package for the tap and activity configuration register bank.
// Assumes a single AHB-Lite master, 32-bit word accesses and one clock domain.
// Notes on behaviour
// - Unlatched tap interrupt lasts the latency window
// - Latched tap interrupt holds until source read
// - Seven-bit tap threshold resets zero, below latch
// - Seven-bit time limit, top bit unused, zero
// - Full eight-bit latency register, resets zero
// - Activity threshold applies only in low power
// - Activity duration equals (8*value+1)/output_data_rate
package tap_act_pkg;

  // Printed offsets are not word multiples: they are indices, byte address = 4*index
  localparam logic [7:0] idx_tap_ths    = 8'h3A;
  localparam logic [7:0] idx_tap_limit  = 8'h3B;
  localparam logic [7:0] idx_tap_lat    = 8'h3C;
  localparam logic [7:0] idx_tap_win    = 8'h3D;
  localparam logic [7:0] idx_activity_threshold    = 8'h3E;
  localparam logic [7:0] idx_activity_duration    = 8'h3F;
  localparam logic [7:0] idx_tap_src    = 8'h39;
  localparam logic [7:0] idx_mode_ctrl  = 8'h40;

  localparam int         latch_bit      = 7;
  localparam int         ths_msb        = 6;
  localparam logic [7:0] rst_tap_ths    = 8'h00;
  localparam logic [7:0] rst_tap_limit  = 8'h00;
  localparam logic [7:0] rst_tap_lat    = 8'h00;
  localparam logic [7:0] rst_tap_win    = 8'h00;
  localparam logic [7:0] rst_activity_threshold    = 8'h00;
  localparam logic [7:0] rst_activity_duration    = 8'h00;
  localparam logic [7:0] rst_mode_ctrl  = 8'h00;

  // Mode control field positions
  localparam int         fs_lsb         = 0;
  localparam int         lp_bit         = 2;

  // Threshold step in mg per full-scale code 0..3
  localparam logic [7:0] step_2g        = 8'h10;
  localparam logic [7:0] step_4g        = 8'h20;
  localparam logic [7:0] step_8g        = 8'h3E;
  localparam logic [7:0] step_16g       = 8'hBA;

  localparam logic [1:0] htrans_nonseq  = 2'h2;

  typedef struct packed {
    logic        latch;
    logic [6:0]  ths;
    logic [6:0]  limit;
    logic [7:0]  latency;
    logic [7:0]  window;
    logic [6:0]  activity_threshold;
    logic [7:0]  activity_duration;
    logic [1:0]  fs;
    logic        low_power;
  } tap_cfg_t;

endpackage

// [tap_act_regs.sv]
// AHB-Lite slave holding the tap and activity configuration registers.
// Assumes one AHB-Lite master; the tap detector supplies events and ticks.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
module tap_act_regs (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic [31:0] hrdata,
  output      logic        hreadyout,
  output      logic        hresp,
  input  wire logic        tap_event,
  input  wire logic [7:0]  tap_source_in,
  input  wire logic        odr_tick,
  output      logic        tap_irq,
  output      tap_act_pkg::tap_cfg_t cfg,
  output      logic [15:0] activity_threshold_mg,
  output      logic [11:0] activity_duration_ticks
);
  logic [7:0] ths_reg;
  logic [7:0] limit_reg;
  logic [7:0] lat_reg;
  logic [7:0] win_reg;
  logic [7:0] activity_threshold_reg;
  logic [7:0] activity_duration_reg;
  logic [7:0] mode_reg;
  logic [7:0] ths_next;
  logic [7:0] limit_next;
  logic [7:0] lat_next;
  logic [7:0] win_next;
  logic [7:0] activity_threshold_next;
  logic [7:0] activity_duration_next;
  logic [7:0] mode_next;
  logic       wr_pend_reg;
  logic [7:0] wr_idx_reg;
  logic [7:0] rd_data_next;
  logic [7:0] step_next;
  logic       src_read;
  logic [6:0] act_eff;
  wire        take = hsel && hready && htrans == tap_act_pkg::htrans_nonseq;
  wire  [7:0] idx  = haddr[9:2];

  // Single-cycle answer: ready from the first clock after reset (low during reset), always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 8'h00;
    end else begin
      wr_pend_reg <= take && hwrite;
      wr_idx_reg  <= idx;
    end
  end

  // A register keeps its contents unless the current data phase writes it
  always_comb begin
    ths_next     = ths_reg;
    limit_next   = limit_reg;
    lat_next     = lat_reg;
    win_next     = win_reg;
    activity_threshold_next = activity_threshold_reg;
    activity_duration_next = activity_duration_reg;
    mode_next    = mode_reg;
    if (wr_pend_reg) begin
      case (wr_idx_reg)
        tap_act_pkg::idx_tap_ths:   ths_next     = hwdata[7:0];
        tap_act_pkg::idx_tap_limit: limit_next   = {1'b0, hwdata[6:0]};
        tap_act_pkg::idx_tap_lat:   lat_next     = hwdata[7:0];
        tap_act_pkg::idx_tap_win:   win_next     = hwdata[7:0];
        tap_act_pkg::idx_activity_threshold:   activity_threshold_next = {1'b0, hwdata[6:0]};
        tap_act_pkg::idx_activity_duration:   activity_duration_next = hwdata[7:0];
        tap_act_pkg::idx_mode_ctrl: mode_next    = {5'h00, hwdata[2:0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ths_reg <= tap_act_pkg::rst_tap_ths;
    end else begin
      ths_reg <= ths_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      limit_reg <= tap_act_pkg::rst_tap_limit;
    end else begin
      limit_reg <= limit_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lat_reg <= tap_act_pkg::rst_tap_lat;
    end else begin
      lat_reg <= lat_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win_reg <= tap_act_pkg::rst_tap_win;
    end else begin
      win_reg <= win_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      activity_threshold_reg <= tap_act_pkg::rst_activity_threshold;
    end else begin
      activity_threshold_reg <= activity_threshold_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      activity_duration_reg <= tap_act_pkg::rst_activity_duration;
    end else begin
      activity_duration_reg <= activity_duration_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= tap_act_pkg::rst_mode_ctrl;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Reading the next values lets a read right behind a write see the new data
  always_comb begin
    case (idx)
      tap_act_pkg::idx_tap_ths:   rd_data_next = ths_next;
      tap_act_pkg::idx_tap_limit: rd_data_next = limit_next;
      tap_act_pkg::idx_tap_lat:   rd_data_next = lat_next;
      tap_act_pkg::idx_tap_win:   rd_data_next = win_next;
      tap_act_pkg::idx_activity_threshold:   rd_data_next = activity_threshold_next;
      tap_act_pkg::idx_activity_duration:   rd_data_next = activity_duration_next;
      tap_act_pkg::idx_mode_ctrl: rd_data_next = mode_next;
      tap_act_pkg::idx_tap_src:   rd_data_next = {1'b0, tap_source_in[6:0] | {tap_irq, 6'h00}};
      default:                    rd_data_next = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h0000_0000;
    else if (take && !hwrite) hrdata <= {24'h000000, rd_data_next};
  end

  // Source read clears a latched interrupt
  assign src_read = take && !hwrite && idx == tap_act_pkg::idx_tap_src;

  tap_irq_timer #(.cnt_w(8)) u_irq (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .tap_event (tap_event),
    .odr_tick  (odr_tick),
    .latch_sel (ths_reg[tap_act_pkg::latch_bit]),
    .latency   (lat_reg),
    .src_read  (src_read),
    .irq_reg   (tap_irq)
  );

  always_comb begin
    case (mode_reg[tap_act_pkg::fs_lsb +: 2])
      2'h0:    step_next = tap_act_pkg::step_2g;
      2'h1:    step_next = tap_act_pkg::step_4g;
      2'h2:    step_next = tap_act_pkg::step_8g;
      default: step_next = tap_act_pkg::step_16g;
    endcase
  end

  // Threshold only takes effect in low-power mode
  assign act_eff = mode_reg[tap_act_pkg::lp_bit] ? activity_threshold_reg[6:0] : 7'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg           <= '0;
      activity_threshold_mg    <= 16'h0000;
      activity_duration_ticks <= 12'h000;
    end else begin
      cfg.latch     <= ths_reg[tap_act_pkg::latch_bit];
      cfg.ths       <= ths_reg[tap_act_pkg::ths_msb:0];
      cfg.limit     <= limit_reg[6:0];
      cfg.latency   <= lat_reg;
      cfg.window    <= win_reg;
      cfg.activity_threshold   <= act_eff;
      cfg.activity_duration   <= activity_duration_reg;
      cfg.fs        <= mode_reg[tap_act_pkg::fs_lsb +: 2];
      cfg.low_power <= mode_reg[tap_act_pkg::lp_bit];
      activity_threshold_mg    <= 16'(act_eff) * 16'(step_next);
      activity_duration_ticks <= {1'b0, activity_duration_reg, 3'h0} + 12'h001;
    end
  end
endmodule // tap_act_regs

// [tap_irq_timer.sv]
// Tap interrupt output stage: pulse of latency length or latched.
// Assumes tap events and output-data-rate ticks arrive as one-cycle pulses.
`timescale 1ns/1ps
module tap_irq_timer #(
  parameter int cnt_w = 8
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             tap_event,
  input  wire logic             odr_tick,
  input  wire logic             latch_sel,
  input  wire logic [cnt_w-1:0] latency,
  input  wire logic             src_read,
  output      logic             irq_reg
);
  logic [cnt_w-1:0] count_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_reg   <= 1'b0;
      count_reg <= '0;
    end else if (tap_event) begin
      // New event wins over a clear in the same cycle
      irq_reg   <= 1'b1;
      count_reg <= latency;
    end else if (irq_reg) begin
      if (latch_sel) begin
        if (src_read) irq_reg <= 1'b0;
      end else if (count_reg == '0) begin
        irq_reg <= 1'b0;
      end else if (odr_tick) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // tap_irq_timer

// [tb.sv]
// Self-checking bench for tap_act_regs over AHB-Lite.
// Assumes the bench drives every input of the bank except hready, which is looped back from hreadyout.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tb;
  logic                  hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic                  tap_event = 1'b0, odr_tick = 1'b0, hreadyout, hresp, tap_irq;
  logic [31:0]           haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]            htrans = 2'h0;
  logic [2:0]            hsize = 3'h2;
  logic [15:0]           activity_threshold_mg;
  logic [11:0]           activity_duration_ticks;
  tap_act_pkg::tap_cfg_t cfg;
  int                    n_mismatch = 0, check_count = 0, cyc = 0;
  logic [7:0]            wexp [6] = '{8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'h7F, 8'hFF};
  logic [7:0]            src_in = 8'h00;
  logic [15:0]           stp [4] = '{16'h0010, 16'h0020, 16'h003E, 16'h00BA};
  always #20 hclk = ~hclk;
  tap_act_regs dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .tap_event, .tap_source_in(src_in),
    .odr_tick, .tap_irq, .cfg, .activity_threshold_mg, .activity_duration_ticks);
  task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {22'h0, i, 2'h0}; htrans <= 2'h2; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] i, input logic [31:0] e);
    xfer(1'b0, i, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      repeat (3) @(posedge hclk);
      odr_tick <= 1'b1;
      @(posedge hclk);
      odr_tick <= 1'b0;
    end
    repeat (2) @(posedge hclk);
    #1;
  endtask
  task automatic tap;
    @(posedge hclk);
    tap_event <= 1'b1;
    @(posedge hclk);
    tap_event <= 1'b0;
  endtask
  task automatic t_reset;
    for (int k = 8'h39; k <= 8'h40; k++) rd_chk(8'(k), 32'h0);
    tap();
    tick(0);
    `CHK(tap_irq, 1'b0)
  endtask
  task automatic t_rw;
    // Upper data lanes are written high to prove they are dropped
    for (int k = 0; k < 6; k++) begin
      xfer(1'b1, tap_act_pkg::idx_tap_ths + 8'(k), 32'hFFFF_FFFF);
      rd_chk(tap_act_pkg::idx_tap_ths + 8'(k), {24'h0, wexp[k]});
    end
    xfer(1'b1, 8'h20, 32'h0000_00FF);
    rd_chk(8'h20, 32'h0);
    `CHK({cfg.latch, cfg.ths, cfg.limit, cfg.latency, cfg.window}, 31'h7FFF_FFFF)
  endtask
  task automatic t_act;
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, tap_act_pkg::idx_mode_ctrl, 32'h4 + 32'(k));
      tick(0);
      `CHK(activity_threshold_mg, 16'h007F * stp[k])
      `CHK(cfg.fs, 2'(k))
      `CHK(cfg.activity_threshold, 7'h7F)
    end
    xfer(1'b1, tap_act_pkg::idx_mode_ctrl, 32'h0);
    tick(0);
    `CHK(activity_threshold_mg, 16'h0000)
    `CHK(activity_duration_ticks, 12'h7F9)
  endtask
  task automatic t_unl;
    xfer(1'b1, tap_act_pkg::idx_tap_ths, 32'h0);
    xfer(1'b1, tap_act_pkg::idx_tap_lat, 32'h3);
    tap();
    tick(2);
    `CHK(tap_irq, 1'b1)
    tick(1);
    `CHK(tap_irq, 1'b0)
  endtask
  task automatic t_lat;
    xfer(1'b1, tap_act_pkg::idx_tap_ths, 32'h80);
    tap();
    // Bit 7 of the source input must not reach the bus
    src_in <= 8'h95;
    tick(5);
    `CHK(tap_irq, 1'b1)
    rd_chk(tap_act_pkg::idx_tap_src, 32'h55);
    #1;
    `CHK(tap_irq, 1'b0)
  endtask
  task automatic t_rst2;
    // A reset in mid-run drops a latched interrupt and restores the defaults
    tap();
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    #1;
    `CHK(tap_irq, 1'b0)
    rd_chk(tap_act_pkg::idx_tap_ths, 32'h0);
    rd_chk(tap_act_pkg::idx_tap_lat, 32'h0);
  endtask
  task complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_reset();
    t_rw();
    t_act();
    t_unl();
    t_lat();
    t_rst2();
    complete_run();
  end
endmodule // tb
